// ### rtl/adc_pkg.sv
`default_nettype none
package adc_pkg;
   // register offsets on the plain register port
   localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
   localparam logic [7:0] OFS_CTRL_TWO   = 8'h01;
   localparam logic [7:0] OFS_RES_HIGH   = 8'h02;
   localparam logic [7:0] OFS_RES_LOW    = 8'h03;
   localparam logic [7:0] OFS_CMP_HIGH   = 8'h04;
   localparam logic [7:0] OFS_CMP_LOW    = 8'h05;
   localparam logic [7:0] OFS_CONFIG     = 8'h06;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h07;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h08;

   // status_control_one fields
   localparam int BIT_COMPLETE   = 7;
   localparam int BIT_CONTINUOUS = 5;
   localparam int CHAN_MSB       = 4;
   // status_control_two fields
   localparam int BIT_ACTIVE     = 7;
   localparam int BIT_TRIG_SEL   = 6;
   localparam int BIT_CMP_EN     = 5;
   localparam int BIT_CMP_GE     = 4;
   // configuration field: conversion mode in bits 3:2
   localparam int MODE_LSB       = 2;
   localparam logic [1:0] MODE_8BIT  = 2'h0;
   localparam logic [1:0] MODE_10BIT = 2'h2;
   // interrupt status bits
   localparam int IRQ_COMPLETE   = 0;
   localparam int IRQ_DISCARD    = 1;

   localparam logic [4:0] CHAN_OFF    = 5'h1F;
   localparam logic [7:0] RESET_BYTE  = 8'h00;
   localparam logic [9:0] RESET_WORD  = 10'h000;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   typedef struct packed {
      logic       done;
      logic [9:0] data;
   } conv_result_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_CONV = 1'b1
   } conv_state_t;
endpackage
`default_nettype wire

// ### rtl/adc_compare_result_control.sv
`timescale 1ns/1ps
`default_nettype none
module adc_compare_result_control (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire adc_pkg::reg_req_t     bus_req,
   output var  logic [7:0]            rdata,
   input  wire logic                  hardware_trigger_input,
   input  wire adc_pkg::conv_result_t conv_in,
   output var  logic                  conv_start,
   output var  logic                  conv_abort,
   output var  logic                  conversion_active,
   output var  logic                  irq
);

   // compare outcome, shared by the load and the flag logic
   function automatic logic cmp_true(input logic [9:0] res, input logic [9:0] cv,
                                     input logic ten, input logic ge);
      logic lt;
      lt = ten ? (res < cv) : (res[7:0] < cv[7:0]);
      cmp_true = ge ? !lt : lt;
   endfunction

   logic                 complete_ff;
   logic                 continuous_ff;
   logic [4:0]           channel_select_ff;
   logic                 trigger_select_ff;
   logic                 compare_enable_ff;
   logic                 compare_greater_equal_ff;
   logic [1:0]           mode_ff;
   logic [7:0]           result_high_ff;
   logic [7:0]           result_low_ff;
   logic [1:0]           compare_value_high_ff;
   logic [7:0]           compare_value_low_ff;
   logic                 lock_ff;
   logic [1:0]           irq_status_ff;
   logic [1:0]           irq_mask_ff;
   logic [2:0]           trig_sync_ff;
   logic                 trig_stable_ff;
   adc_pkg::conv_state_t state_ff;
   adc_pkg::conv_state_t nxt_state;

   logic wr_one;
   logic rd_high;
   logic rd_low;
   logic rd_irq;
   logic ten_bit;
   logic chan_on;
   logic hw_edge;
   logic start_req;
   logic finish;
   logic cmp_ok;
   logic accept;
   logic load;
   logic discard;

   // access decode
   always_comb begin
      wr_one  = bus_req.wr && (bus_req.addr == adc_pkg::OFS_CTRL_ONE);
      rd_high = bus_req.rd && (bus_req.addr == adc_pkg::OFS_RES_HIGH);
      rd_low  = bus_req.rd && (bus_req.addr == adc_pkg::OFS_RES_LOW);
      rd_irq  = bus_req.rd && (bus_req.addr == adc_pkg::OFS_IRQ_STATUS);
   end

   // conversion control terms
   always_comb begin
      ten_bit = (mode_ff == adc_pkg::MODE_10BIT);
      // a control-one write starts on the channel being written, not the old one
      chan_on = wr_one ? (bus_req.wdata[4:0] != adc_pkg::CHAN_OFF)
                       : (channel_select_ff != adc_pkg::CHAN_OFF);
      hw_edge = (trig_sync_ff[1] == trig_sync_ff[2]) && trig_sync_ff[1] && !trig_stable_ff;
      finish  = (state_ff == adc_pkg::ST_CONV) && conv_in.done && !wr_one;
      cmp_ok  = cmp_true(conv_in.data,
                         {compare_value_high_ff, compare_value_low_ff},
                         ten_bit, compare_greater_equal_ff);
      accept  = finish && (!compare_enable_ff || cmp_ok);
      load    = accept && !(lock_ff && ten_bit);
      discard = accept && lock_ff && ten_bit;
   end

   // start sources; a control-one write in hardware mode only aborts
   always_comb begin
      if (!chan_on) begin
         start_req = 1'b0;
      end else if (trigger_select_ff) begin
         start_req = hw_edge || (finish && continuous_ff && !wr_one);
      end else begin
         start_req = wr_one || (finish && continuous_ff);
      end
   end

   always_comb begin
      case (state_ff)
         adc_pkg::ST_IDLE: nxt_state = start_req ? adc_pkg::ST_CONV : adc_pkg::ST_IDLE;
         adc_pkg::ST_CONV: begin
            if (start_req) begin
               nxt_state = adc_pkg::ST_CONV;
            end else if (wr_one || finish) begin
               nxt_state = adc_pkg::ST_IDLE;
            end else begin
               nxt_state = adc_pkg::ST_CONV;
            end
         end
         default: nxt_state = adc_pkg::ST_IDLE;
      endcase
   end

   // conversion state; active bit mirrors it
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= adc_pkg::ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // strobes to the analog converter, one cycle each; conversion_active is a level held for the whole conversion
   always_ff @(posedge clk) begin
      if (rst) begin
         conv_start        <= 1'b0;
         conv_abort        <= 1'b0;
         conversion_active <= 1'b0;
      end else begin
         conv_start        <= start_req;
         conv_abort        <= wr_one && (state_ff == adc_pkg::ST_CONV);
         conversion_active <= (nxt_state == adc_pkg::ST_CONV);
      end
   end

   // trigger pin: three flops, change counted when stages two and three agree
   always_ff @(posedge clk) begin
      if (rst) begin
         trig_sync_ff   <= 3'h0;
         trig_stable_ff <= 1'b0;
      end else begin
         trig_sync_ff <= {trig_sync_ff[1:0], hardware_trigger_input};
         if (trig_sync_ff[1] == trig_sync_ff[2]) begin
            trig_stable_ff <= trig_sync_ff[2];
         end
      end
   end

   // control registers written by software
   always_ff @(posedge clk) begin
      if (rst) begin
         continuous_ff            <= 1'b0;
         channel_select_ff        <= 5'h00;
         trigger_select_ff        <= 1'b0;
         compare_enable_ff        <= 1'b0;
         compare_greater_equal_ff <= 1'b0;
         mode_ff                  <= adc_pkg::MODE_8BIT;
         compare_value_high_ff    <= 2'h0;
         compare_value_low_ff     <= adc_pkg::RESET_BYTE;
         irq_mask_ff              <= 2'h0;
      end else if (bus_req.wr) begin
         if (bus_req.addr == adc_pkg::OFS_CTRL_ONE) begin
            continuous_ff     <= bus_req.wdata[adc_pkg::BIT_CONTINUOUS];
            channel_select_ff <= bus_req.wdata[adc_pkg::CHAN_MSB:0];
         end else if (bus_req.addr == adc_pkg::OFS_CTRL_TWO) begin
            // reserved low bits are not stored; software keeps them zero
            trigger_select_ff        <= bus_req.wdata[adc_pkg::BIT_TRIG_SEL];
            compare_enable_ff        <= bus_req.wdata[adc_pkg::BIT_CMP_EN];
            compare_greater_equal_ff <= bus_req.wdata[adc_pkg::BIT_CMP_GE];
         end else if (bus_req.addr == adc_pkg::OFS_CMP_HIGH) begin
            compare_value_high_ff <= bus_req.wdata[1:0];
         end else if (bus_req.addr == adc_pkg::OFS_CMP_LOW) begin
            compare_value_low_ff <= bus_req.wdata;
         end else if (bus_req.addr == adc_pkg::OFS_CONFIG) begin
            // old results stay; software must not trust them after this
            mode_ff <= bus_req.wdata[adc_pkg::MODE_LSB +: 2];
         end else if (bus_req.addr == adc_pkg::OFS_IRQ_MASK) begin
            irq_mask_ff <= bus_req.wdata[1:0];
         end
      end
   end

   // result registers
   always_ff @(posedge clk) begin
      if (rst) begin
         result_high_ff <= adc_pkg::RESET_BYTE;
         result_low_ff  <= adc_pkg::RESET_BYTE;
      end else if (load) begin
         result_high_ff <= ten_bit ? {6'h00, conv_in.data[9:8]} : 8'h00;
         result_low_ff  <= conv_in.data[7:0];
      end
   end

   // read interlock, 10-bit only; lock from a high read outlives mode edits
   always_ff @(posedge clk) begin
      if (rst) begin
         lock_ff <= 1'b0;
      end else if (rd_low) begin
         lock_ff <= 1'b0;
      end else if (rd_high && ten_bit) begin
         lock_ff <= 1'b1;
      end
   end

   // complete flag: a new completion beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         complete_ff <= 1'b0;
      end else if (accept) begin
         complete_ff <= 1'b1;
      end else if (wr_one || rd_low) begin
         complete_ff <= 1'b0;
      end
   end

   // sticky event bits, cleared by reading them, set wins
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_status_ff <= 2'h0;
      end else begin
         irq_status_ff[adc_pkg::IRQ_COMPLETE] <= accept ||
            (irq_status_ff[adc_pkg::IRQ_COMPLETE] && !rd_irq);
         irq_status_ff[adc_pkg::IRQ_DISCARD]  <= discard ||
            (irq_status_ff[adc_pkg::IRQ_DISCARD] && !rd_irq);
      end
   end

   // level interrupt, one cycle behind the status bits
   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status_ff & irq_mask_ff);
      end
   end

   // read data, valid the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= adc_pkg::RESET_BYTE;
      end else if (!bus_req.rd) begin
         rdata <= adc_pkg::RESET_BYTE;
      end else if (bus_req.addr == adc_pkg::OFS_CTRL_ONE) begin
         rdata <= {complete_ff, 1'b0, continuous_ff, channel_select_ff};
      end else if (bus_req.addr == adc_pkg::OFS_CTRL_TWO) begin
         rdata <= {(state_ff == adc_pkg::ST_CONV), trigger_select_ff,
                   compare_enable_ff, compare_greater_equal_ff, 4'h0};
      end else if (bus_req.addr == adc_pkg::OFS_RES_HIGH) begin
         rdata <= result_high_ff;
      end else if (bus_req.addr == adc_pkg::OFS_RES_LOW) begin
         rdata <= result_low_ff;
      end else if (bus_req.addr == adc_pkg::OFS_CMP_HIGH) begin
         rdata <= {6'h00, compare_value_high_ff};
      end else if (bus_req.addr == adc_pkg::OFS_CMP_LOW) begin
         rdata <= compare_value_low_ff;
      end else if (bus_req.addr == adc_pkg::OFS_CONFIG) begin
         rdata <= {4'h0, mode_ff, 2'h0};
      end else if (bus_req.addr == adc_pkg::OFS_IRQ_STATUS) begin
         rdata <= {6'h00, irq_status_ff};
      end else if (bus_req.addr == adc_pkg::OFS_IRQ_MASK) begin
         rdata <= {6'h00, irq_mask_ff};
      end else begin
         rdata <= adc_pkg::RESET_BYTE;
      end
   end

   // checks
   a_active_tracks: assert property (@(posedge clk) disable iff (rst)
      start_req |=> conversion_active && (state_ff == adc_pkg::ST_CONV))
      else $error("active bit not set after start");
   a_sw_start: assert property (@(posedge clk) disable iff (rst)
      (wr_one && !trigger_select_ff && bus_req.wdata[4:0] != adc_pkg::CHAN_OFF
       && chan_on) |=> conv_start)
      else $error("software write did not start conversion");
   a_hw_no_write: assert property (@(posedge clk) disable iff (rst)
      (wr_one && trigger_select_ff && !hw_edge && !finish) |=> !conv_start)
      else $error("write started conversion in hardware mode");
   a_compare_skip: assert property (@(posedge clk) disable iff (rst)
      (finish && compare_enable_ff && !cmp_ok) |=> $stable(result_low_ff) && $stable(result_high_ff))
      else $error("result loaded on false compare");
   a_high_zero_8b: assert property (@(posedge clk) disable iff (rst)
      (load && !ten_bit) |=> result_high_ff == 8'h00)
      else $error("high result not zero in 8-bit mode");
   a_lock_discard: assert property (@(posedge clk) disable iff (rst)
      (lock_ff && ten_bit && !rd_low) |=> $stable(result_low_ff))
      else $error("result changed while lock held");
   a_no_lock_8b: assert property (@(posedge clk) disable iff (rst)
      (accept && !ten_bit) |=> result_low_ff == $past(conv_in.data[7:0]))
      else $error("8-bit result not loaded");
   a_flag_cmp: assert property (@(posedge clk) disable iff (rst)
      (finish && compare_enable_ff && !cmp_ok && !complete_ff) |=> !complete_ff)
      else $error("complete flag set on false compare");
   a_abort_write: assert property (@(posedge clk) disable iff (rst)
      (wr_one && state_ff == adc_pkg::ST_CONV) |=> conv_abort ##1
      (conv_abort == $past(wr_one && state_ff == adc_pkg::ST_CONV)))
      else $error("write did not abort conversion");
   a_reset_clear: assert property (@(posedge clk)
      rst |=> !trigger_select_ff && !compare_enable_ff && result_low_ff == 8'h00)
      else $error("reset left state set");

   // compare outcomes, one direction at a time
   a_ge_loads: assert property (@(posedge clk) disable iff (rst)
      (finish && compare_enable_ff && compare_greater_equal_ff && ten_bit && !lock_ff
       && conv_in.data >= {compare_value_high_ff, compare_value_low_ff})
      |=> result_low_ff == $past(conv_in.data[7:0]))
      else $error("greater-equal compare did not load");
   a_lt_loads_8b: assert property (@(posedge clk) disable iff (rst)
      (finish && compare_enable_ff && !compare_greater_equal_ff && !ten_bit
       && conv_in.data[7:0] < compare_value_low_ff) |=> result_low_ff == $past(conv_in.data[7:0]))
      else $error("less-than compare did not load");
   a_high_cv_ignored: assert property (@(posedge clk) disable iff (rst)
      (finish && compare_enable_ff && !compare_greater_equal_ff && !ten_bit
       && conv_in.data[7:0] >= compare_value_low_ff) |=> $stable(result_low_ff))
      else $error("8-bit compare used high compare bits");
   a_cmp_off_loads: assert property (@(posedge clk) disable iff (rst)
      (finish && !compare_enable_ff && !(lock_ff && ten_bit)) |=> result_low_ff == $past(conv_in.data[7:0]))
      else $error("result not loaded with compare off");
   a_high_ten: assert property (@(posedge clk) disable iff (rst)
      (load && ten_bit) |=> result_high_ff == {6'h00, $past(conv_in.data[9:8])})
      else $error("high result bits not loaded");

   // read interlock and discard
   a_lock_set: assert property (@(posedge clk) disable iff (rst)
      (rd_high && ten_bit) |=> lock_ff)
      else $error("high read did not set lock");
   a_lock_quiet_8b: assert property (@(posedge clk) disable iff (rst)
      (rd_high && !ten_bit && !lock_ff) |=> !lock_ff)
      else $error("lock set in 8-bit mode");
   a_discard_event: assert property (@(posedge clk) disable iff (rst)
      discard |=> irq_status_ff[adc_pkg::IRQ_DISCARD])
      else $error("discard event not recorded");

   // conversion start, stop and flag
   a_active_clear: assert property (@(posedge clk) disable iff (rst)
      (finish && !start_req) |=> !conversion_active)
      else $error("active bit not cleared on completion");
   a_hw_start: assert property (@(posedge clk) disable iff (rst)
      (hw_edge && trigger_select_ff && chan_on) |=> conv_start && conversion_active)
      else $error("trigger input did not start conversion");
   a_chan_off: assert property (@(posedge clk) disable iff (rst)
      (wr_one && bus_req.wdata[4:0] == adc_pkg::CHAN_OFF) |=> !conv_start)
      else $error("write with channel off started conversion");
   a_abort_idle: assert property (@(posedge clk) disable iff (rst)
      (wr_one && state_ff == adc_pkg::ST_IDLE) |=> !conv_abort)
      else $error("abort raised while idle");
   a_flag_set: assert property (@(posedge clk) disable iff (rst)
      accept |=> complete_ff)
      else $error("complete flag not set");

   // bus and interrupt outputs
   a_rdata_quiet: assert property (@(posedge clk) disable iff (rst)
      !bus_req.rd |=> rdata == adc_pkg::RESET_BYTE)
      else $error("read data not zero outside read");
   a_irq_level: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> irq == $past(|(irq_status_ff & irq_mask_ff)))
      else $error("interrupt level does not follow status");
   a_reset_outputs: assert property (@(posedge clk)
      rst |=> !conv_start && !conv_abort && !conversion_active && !irq && rdata == adc_pkg::RESET_BYTE)
      else $error("reset left an output set");

endmodule // adc_compare_result_control
`default_nettype wire

// ### tb/adc_compare_result_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_compare_result_control_tb;
   logic                  clk;
   logic                  rst;
   adc_pkg::reg_req_t     bus_req;
   logic [7:0]            rdata;
   logic                  hardware_trigger_input;
   adc_pkg::conv_result_t conv_in;
   logic                  conv_start;
   logic                  conv_abort;
   logic                  conversion_active;
   logic                  irq;
   int                    fail_count;
   int                    tests_run;
   int                    start_cnt;
   int                    abort_cnt;
   int                    s0;
   int                    a0;
   int                    w;
   logic [15:0]           exp_q[$];
   logic [15:0]           mon_e;
   logic                  rd_seen;
   // reference copy of what software should see
   logic [1:0]            m_hi, cvh, ist, msk, mode;
   logic [7:0]            m_lo, cvl;
   logic                  complete, lock, trig, cen, cge;
   logic [4:0]            chan;

   adc_compare_result_control i_dut (
      .clk                    (clk),
      .rst                    (rst),
      .bus_req                (bus_req),
      .rdata                  (rdata),
      .hardware_trigger_input (hardware_trigger_input),
      .conv_in                (conv_in),
      .conv_start             (conv_start),
      .conv_abort             (conv_abort),
      .conversion_active      (conversion_active),
      .irq                    (irq)
   );

   initial clk = 1'b0;
   always #25 clk = ~clk;

   // read data stands only in the cycle after the strobe, so compare then
   always @(posedge clk) begin
      if (rd_seen) begin
         mon_e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'h0000;
         tests_run++;
         if ((rdata & mon_e[7:0]) !== (mon_e[15:8] & mon_e[7:0])) begin
            $display("wrong value rdata expected %h seen %h", mon_e[15:8], rdata);
            fail_count++;
         end
      end
      rd_seen <= bus_req.rd;
      if (conv_start === 1'b1) start_cnt <= start_cnt + 1;
      if (conv_abort === 1'b1) abort_cnt <= abort_cnt + 1;
   end

   task automatic chk(input logic [7:0] e, input logic [7:0] g, input string n);
      tests_run++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // one assignment per edge keeps strobes one cycle long
   task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic wr_s, input logic rd_s);
      bus_req <= '{a, d, wr_s, rd_s};
      @(posedge clk);
   endtask

   task automatic idle();
      bus(8'h00, 8'h00, 1'b0, 1'b0);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      case (a)
         8'h00: begin complete = 1'b0; chan = d[4:0]; end
         8'h01: {trig, cen, cge} = d[6:4];
         8'h04: cvh = d[1:0];
         8'h05: cvl = d;
         8'h06: mode = d[3:2];
         8'h08: msk = d[1:0];
         default: ;
      endcase
      bus(a, d, 1'b1, 1'b0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] m);
      logic [7:0] e;
      case (a)
         8'h00: e = {complete, 2'h0, chan};
         8'h01: e = {1'b0, trig, cen, cge, 4'h0};
         8'h02: e = {6'h00, m_hi};
         8'h03: e = m_lo;
         8'h04: e = {6'h00, cvh};
         8'h05: e = cvl;
         8'h06: e = {4'h0, mode, 2'h0};
         8'h07: e = {6'h00, ist};
         8'h08: e = {6'h00, msk};
         default: e = 8'h00;
      endcase
      exp_q.push_back({e, m});
      if (a == 8'h02 && mode == 2'h2) lock = 1'b1;
      if (a == 8'h03) begin lock = 1'b0; complete = 1'b0; end
      if (a == 8'h07) ist = 2'h0;
      bus(a, 8'h00, 1'b0, 1'b1);
   endtask

   task automatic start_sw();
      wr(8'h00, 8'h00);
      idle();
      chk(8'h01, {7'h00, conversion_active}, "active after start");
   endtask

   // completion pulse, then reference update of results and events
   task automatic finish(input logic [9:0] d);
      logic [9:0] v, c;
      logic       ok;
      conv_in <= '{1'b1, d};
      @(posedge clk);
      conv_in <= '{1'b0, ~d};
      @(posedge clk);
      chk(8'h00, {7'h00, conversion_active}, "active after done");
      v = (mode == 2'h2) ? d : {2'h0, d[7:0]};
      c = (mode == 2'h2) ? {cvh, cvl} : {2'h0, cvl};
      ok = !cen || (cge ? (v >= c) : (v < c));
      // an accepted result always flags; the lock only keeps it out of the registers
      if (ok) complete = 1'b1;
      if (ok) ist[0] = 1'b1;
      if (ok && lock && mode == 2'h2) ist[1] = 1'b1;
      else if (ok) begin m_hi = v[9:8]; m_lo = v[7:0]; end
      idle();
      chk({7'h00, |(ist & msk)}, {7'h00, irq}, "irq");
   endtask

   initial begin
      rst = 1'b1;
      bus_req = '0;
      hardware_trigger_input = 1'b0;
      conv_in = '0;
      {fail_count, tests_run, start_cnt, abort_cnt} = '0;
      rd_seen = 1'b0;
      {m_hi, cvh, ist, msk, mode, m_lo, cvl, complete, lock, trig, cen, cge, chan} = '0;
      void'($urandom(32'h39544e5f));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      // reset values, unmapped place reads zero
      for (int a = 0; a < 9; a++) rd(a[7:0], 8'hFF);
      rd(8'h20, 8'hFF);
      wr(8'h08, 8'h03);
      // every mode code against every compare setting, random values
      for (int i = 0; i < 16; i++) begin
         wr(8'h06, {4'h0, 2'(i % 4), 2'h0});
         wr(8'h04, 8'($urandom % 4));
         wr(8'h05, 8'($urandom));
         wr(8'h01, {2'h0, 2'(i / 4), 4'h0});
         start_sw();
         finish(10'($urandom));
         rd(8'h00, 8'hFF);
         rd(8'h02, 8'hFF);
         rd(8'h03, 8'hFF);
         rd(8'h07, 8'hFF);
         rd(8'h01, 8'h7F);
      end
      // control-one write mid-conversion restarts; channel off only aborts
      wr(8'h01, 8'h00);
      wr(8'h00, 8'h03);
      idle();
      idle();
      s0 = start_cnt;
      a0 = abort_cnt;
      wr(8'h00, 8'h04);
      idle();
      chk(8'h01, {7'h00, conversion_active}, "active on restart");
      wr(8'h00, 8'h1F);
      idle();
      idle();
      chk(8'h00, {7'h00, conversion_active}, "active after channel off");
      chk(8'h01, 8'(start_cnt - s0), "restart count");
      chk(8'h02, 8'(abort_cnt - a0), "abort count");
      // hardware trigger mode ignores register writes as a start
      wr(8'h01, 8'h40);
      s0 = start_cnt;
      wr(8'h00, 8'h02);
      idle();
      idle();
      chk(8'h00, 8'(start_cnt - s0), "start in hw mode");
      hardware_trigger_input <= 1'b1;
      w = 0;
      while (conversion_active !== 1'b1 && w < 10) begin
         idle();
         w++;
      end
      if (conversion_active !== 1'b1) begin
         $display("wrong value hw start expected 1 seen 0");
         fail_count++;
         give_verdict();
      end
      hardware_trigger_input <= 1'b0;
      finish(10'h2C7);
      rd(8'h03, 8'hFF);
      // 10-bit interlock: high read holds results until low read
      wr(8'h01, 8'h00);
      wr(8'h06, 8'h08);
      start_sw();
      finish(10'h3A5);
      rd(8'h02, 8'hFF);
      start_sw();
      finish(10'h15A);
      rd(8'h02, 8'hFF);
      rd(8'h03, 8'hFF);
      rd(8'h07, 8'h02);
      start_sw();
      finish(10'h2F0);
      rd(8'h02, 8'hFF);
      rd(8'h03, 8'hFF);
      // 8-bit mode has no interlock, interrupt masked off
      wr(8'h08, 8'h00);
      wr(8'h06, 8'h00);
      start_sw();
      finish(10'h0C3);
      rd(8'h02, 8'hFF);
      start_sw();
      finish(10'h13C);
      rd(8'h03, 8'hFF);
      rd(8'h07, 8'hFF);
      // continuous mode: a completion starts the next conversion at once
      s0 = start_cnt;
      wr(8'h00, 8'h21);
      conv_in <= '{1'b1, 10'h155};
      idle();
      conv_in <= '{1'b0, 10'h000};
      idle();
      idle();
      chk(8'h01, {7'h00, conversion_active}, "active in continuous");
      chk(8'h02, 8'(start_cnt - s0), "continuous starts");
      wr(8'h00, 8'h1F);
      idle();
      idle();
      give_verdict();
   end
endmodule // adc_compare_result_control_tb
`default_nettype wire
